// ===== rtl/csp_pkg.sv
/*
  constants, state type and register map of the scaled pulse output
  and the sixteen point divider table setup.
  assumes one 125 MHz clock and a plain register port.
*/
// Summary of operation
// - Each scaled counter increment queues exactly one output pulse, except one that arrives at a full buffer in a cycle with no pulse leaving, which is dropped.
// - The output rate is one of 20000, 2000, 200 or 10 per second, cycling from last to first and showing the current choice.
// - Pulses that arrive faster than the rate wait in a buffer of up to 9999.
// - A full buffer raises a flashing overflow warning.
// - The table takes 3 to 16 frequency points in inputs per time unit.
// - Each point has its own divider, held within 0.00011 to 999999.
// - Setup first picks time_unit_per_second, time_unit_per_minute, time_unit_per_hour or test, then enters point editing.
// - Confirming point 00 checks the table and returns to run mode if the point count and frequency order are good.
// - A point index above 16 is taken as 16.
// - Each point shows its frequency, then its divider, then moves to the next index, except point 16, which stays at 16.
// - On exit an order fault flashes an error and then shows the bad point.
`default_nettype none

package csp_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned RATE0_HZ = 20000;
  localparam int unsigned RATE1_HZ = 2000;
  localparam int unsigned RATE2_HZ = 200;
  localparam int unsigned RATE3_HZ = 10;
  localparam int unsigned RATE0_CYC = CLK_HZ / RATE0_HZ;
  localparam int unsigned RATE1_CYC = CLK_HZ / RATE1_HZ;
  localparam int unsigned RATE2_CYC = CLK_HZ / RATE2_HZ;
  localparam int unsigned RATE3_CYC = CLK_HZ / RATE3_HZ;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned BAD_MS = 1000;
  localparam int unsigned BAD_CYC = CLK_HZ / 1000 * BAD_MS;
  localparam logic [13:0] BUF_FULL = 14'h270F;
  localparam logic [4:0] PTS_MIN = 5'h03;
  localparam logic [4:0] PTS_MAX = 5'h10;
  // divider in units of 0.00001
  localparam logic [39:0] DIV_MIN = 40'h00_0000_000B;
  localparam logic [39:0] DIV_MAX = 40'h17_4875_6160;
  localparam logic [7:0] A_RATE = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_DLO = 8'h08;
  localparam logic [7:0] A_DHI = 8'h0C;
  localparam logic [7:0] A_KEY = 8'h10;
  localparam logic [7:0] A_VIEW = 8'h14;
  localparam logic [7:0] A_VHI = 8'h18;
  localparam logic [7:0] A_INFO = 8'h1C;
  localparam int unsigned ST_OVF = 16;
  localparam logic [1:0] KEY_OPEN = 2'h1;
  localparam logic [1:0] KEY_NEXT = 2'h2;
  localparam logic [1:0] KEY_ENTER = 2'h3;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [1:0] UNIT_RST = 2'h0;
  typedef enum logic [2:0] {
    L_RUN, L_UNIT, L_POINT, L_FREQ, L_DIV, L_CHECK, L_BAD
  } csp_lin_t;
endpackage

`default_nettype wire

// ===== rtl/csp_top.sv
/*
  scaled pulse output with pending buffer, and the setup sequence
  of the sixteen point frequency/divider table.
  assumes CNT_INC_I is a one-cycle pulse on CLK_I and software
  drives the register port with single-cycle strobes.
*/
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module csp_top #(
  parameter int unsigned R0_CYC = csp_pkg::RATE0_CYC,
  parameter int unsigned R1_CYC = csp_pkg::RATE1_CYC,
  parameter int unsigned R2_CYC = csp_pkg::RATE2_CYC,
  parameter int unsigned R3_CYC = csp_pkg::RATE3_CYC,
  parameter int unsigned BLINK_CYC = csp_pkg::BLINK_CYC,
  parameter int unsigned BAD_CYC = csp_pkg::BAD_CYC
) (
  input wire logic CLK_I, // 125 MHz clock
  input wire logic RST_I, // async reset, high
  input wire logic [7:0] ADDR_I, // register byte address
  input wire logic [31:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [31:0] RDATA_O, // read data, cycle after RD_I
  input wire logic CNT_INC_I, // scaled counter increment
  output logic PULSE_O, // scaled pulse output
  output logic BUFFER_OVERFLOW_WARNING_O, // flashing warning
  output logic FREQUENCY_ORDER_ERROR_O, // flashing table error
  output logic RUN_MODE_O // table setup not active
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [23:0] period(input logic [1:0] s);
    case (s)
      2'h0: period = 24'(R0_CYC);
      2'h1: period = 24'(R1_CYC);
      2'h2: period = 24'(R2_CYC);
      default: period = 24'(R3_CYC);
    endcase
  endfunction
  function automatic logic [39:0] clamp_div(input logic [39:0] v);
    if (v < csp_pkg::DIV_MIN) begin
      clamp_div = csp_pkg::DIV_MIN;
    end else if (v > csp_pkg::DIV_MAX) begin
      clamp_div = csp_pkg::DIV_MAX;
    end else begin
      clamp_div = v;
    end
  endfunction

  logic wr_rate, wr_stat, wr_key, enter, tick, inc, dec;
  logic [1:0] rate_sel_reg, unit_reg;
  logic [23:0] tick_cnt_reg;
  logic [13:0] pend_reg;
  logic ovf_reg, pulse_reg, blink_reg;
  logic [31:0] blink_cnt_reg, bad_cnt_reg, dlo_reg;
  logic [7:0] dhi_reg;
  csp_pkg::csp_lin_t state_reg;
  logic [4:0] idx_reg, last_reg, chk_reg, bad_pt_reg;
  logic [3:0] pi;
  logic [31:0] freq_mem [16];
  logic [39:0] div_mem [16];

  assign wr_rate = WR_I && ADDR_I == csp_pkg::A_RATE;
  assign wr_stat = WR_I && ADDR_I == csp_pkg::A_STAT;
  assign wr_key = WR_I && ADDR_I == csp_pkg::A_KEY;
  assign enter = wr_key && WDATA_I[1:0] == csp_pkg::KEY_ENTER;
  assign pi = 4'(idx_reg - 5'h01);

  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ----------------------------------------------------------
  // output rate and pulse generator
  // ----------------------------------------------------------
  // cycling rate select
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rate_sel_reg <= csp_pkg::RATE_RST;
    end else if (wr_rate && WDATA_I[0]) begin
      rate_sel_reg <= rate_sel_reg + 2'h1;
    end
  end
  rate_wrap_a: assert property (
    wr_rate && WDATA_I[0] && rate_sel_reg == 2'h3
    |=> rate_sel_reg == 2'h0)
    else $error("rate select did not wrap to first");
  // a rate change mid-period ends the current period at the new length, at once if already past it
  assign tick = tick_cnt_reg >= period(rate_sel_reg) - 24'h1;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? 24'h0 : tick_cnt_reg + 24'h1;
    end
  end

  assign dec = tick && pend_reg != 14'h0;
  assign inc = CNT_INC_I;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_reg <= 1'b0;
    end else if (tick) begin
      pulse_reg <= dec;
    end else if (tick_cnt_reg == (period(rate_sel_reg) >> 1)) begin
      pulse_reg <= 1'b0;
    end
  end

  // hold up to the buffer limit
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pend_reg <= '0;
    end else if (inc && !dec && pend_reg != csp_pkg::BUF_FULL) begin
      pend_reg <= pend_reg + 14'h1;
    end else if (dec && !inc) begin
      pend_reg <= pend_reg - 14'h1;
    end
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovf_reg <= 1'b0;
    end else if (inc && !dec && pend_reg >= csp_pkg::BUF_FULL - 14'h1) begin
      ovf_reg <= 1'b1;
    end else if (wr_stat && WDATA_I[csp_pkg::ST_OVF]) begin
      ovf_reg <= 1'b0;
    end
  end

  count_inc_a: assert property (
    inc && !dec && pend_reg != csp_pkg::BUF_FULL
    |=> pend_reg == $past(pend_reg) + 14'h1)
    else $error("increment not queued");
  buf_cap_a: assert property (
    pend_reg <= csp_pkg::BUF_FULL)
    else $error("pending count above limit");
  ovf_set_a: assert property (
    $rose(pend_reg == csp_pkg::BUF_FULL) |-> ovf_reg)
    else $error("full buffer gave no warning");
  drain_a: assert property (
    $rose(pulse_reg) |-> pend_reg ==
      $past(pend_reg) - 14'h1 + {13'h0, $past(inc)})
    else $error("pulse without pending decrement");

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg >= BLINK_CYC - 1) begin
      blink_cnt_reg <= '0;
      blink_reg <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------
  // table setup sequence
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dlo_reg <= '0;
      dhi_reg <= '0;
    end else if (WR_I && ADDR_I == csp_pkg::A_DLO) begin
      dlo_reg <= WDATA_I;
    end else if (WR_I && ADDR_I == csp_pkg::A_DHI) begin
      dhi_reg <= WDATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= csp_pkg::L_RUN;
      unit_reg <= csp_pkg::UNIT_RST;
      idx_reg <= '0;
      last_reg <= '0;
      chk_reg <= '0;
      bad_pt_reg <= '0;
      bad_cnt_reg <= '0;
    end else begin
      case (state_reg)
        csp_pkg::L_RUN: begin
          if (wr_key && WDATA_I[1:0] == csp_pkg::KEY_OPEN) begin
            state_reg <= csp_pkg::L_UNIT;
          end
        end
        // time unit or test, then points
        csp_pkg::L_UNIT: begin
          if (wr_key && WDATA_I[1:0] == csp_pkg::KEY_NEXT) begin
            unit_reg <= unit_reg + 2'h1;
          end else if (enter) begin
            idx_reg <= '0;
            state_reg <= csp_pkg::L_POINT;
          end
        end
        csp_pkg::L_POINT: begin
          if (enter) begin
            if (dlo_reg == 32'h0) begin
              chk_reg <= '0;
              state_reg <= csp_pkg::L_CHECK;
            end else if (dlo_reg > 32'(csp_pkg::PTS_MAX)) begin
              idx_reg <= csp_pkg::PTS_MAX;
              state_reg <= csp_pkg::L_FREQ;
            end else begin
              idx_reg <= dlo_reg[4:0];
              state_reg <= csp_pkg::L_FREQ;
            end
          end
        end
        csp_pkg::L_FREQ: begin
          if (enter) begin
            state_reg <= csp_pkg::L_DIV;
          end
        end
        csp_pkg::L_DIV: begin
          if (enter) begin
            if (idx_reg > last_reg) begin
              last_reg <= idx_reg;
            end
            if (idx_reg != csp_pkg::PTS_MAX) begin
              idx_reg <= idx_reg + 5'h01;
            end
            state_reg <= csp_pkg::L_POINT;
          end
        end
        csp_pkg::L_CHECK: begin
          if (last_reg < csp_pkg::PTS_MIN) begin
            bad_pt_reg <= last_reg + 5'h01;
            state_reg <= csp_pkg::L_BAD;
          end else if (chk_reg == last_reg) begin
            state_reg <= csp_pkg::L_RUN;
          end else if (chk_reg == 5'h00 ? freq_mem[0] != 32'h0 :
              freq_mem[4'(chk_reg)] <= freq_mem[4'(chk_reg - 5'h01)]) begin
            bad_pt_reg <= chk_reg + 5'h01;
            state_reg <= csp_pkg::L_BAD;
          end else begin
            chk_reg <= chk_reg + 5'h01;
          end
          bad_cnt_reg <= '0;
        end
        csp_pkg::L_BAD: begin
          if (bad_cnt_reg >= BAD_CYC - 1) begin
            idx_reg <= bad_pt_reg;
            state_reg <= csp_pkg::L_POINT;
          end else begin
            bad_cnt_reg <= bad_cnt_reg + 32'h1;
          end
        end
        default: state_reg <= csp_pkg::L_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (enter && state_reg == csp_pkg::L_FREQ) begin
      freq_mem[pi] <= dlo_reg;
    end
    if (enter && state_reg == csp_pkg::L_DIV) begin
      div_mem[pi] <= clamp_div({dhi_reg, dlo_reg});
    end
  end
  exit_a: assert property (
    state_reg == csp_pkg::L_POINT && enter && dlo_reg == 32'h0
    |=> state_reg == csp_pkg::L_CHECK)
    else $error("point 00 did not end setup");
  clamp_a: assert property (
    state_reg == csp_pkg::L_POINT && enter && dlo_reg != 32'h0
    |=> state_reg == csp_pkg::L_FREQ && idx_reg == ($past(dlo_reg) >
      {27'h0, csp_pkg::PTS_MAX} ? csp_pkg::PTS_MAX : $past(dlo_reg[4:0])))
    else $error("point index not clamped");
  seq_a: assert property (
    state_reg == csp_pkg::L_FREQ && enter
    |=> state_reg == csp_pkg::L_DIV && idx_reg == $past(idx_reg))
    else $error("frequency not followed by divider");
  div_rng_a: assert property (
    state_reg == csp_pkg::L_DIV && enter |=>
      div_mem[$past(pi)] >= csp_pkg::DIV_MIN
      && div_mem[$past(pi)] <= csp_pkg::DIV_MAX)
    else $error("divider out of range");
  bad_ret_a: assert property (
    state_reg == csp_pkg::L_BAD && $past(state_reg) == csp_pkg::L_BAD
    ##1 state_reg == csp_pkg::L_POINT |-> idx_reg == bad_pt_reg)
    else $error("bad point not shown after error");

  // ----------------------------------------------------------
  // outputs and register reads
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PULSE_O <= 1'b0;
      BUFFER_OVERFLOW_WARNING_O <= 1'b0;
      FREQUENCY_ORDER_ERROR_O <= 1'b0;
      RUN_MODE_O <= 1'b1;
    end else begin
      PULSE_O <= pulse_reg;
      BUFFER_OVERFLOW_WARNING_O <= ovf_reg && blink_reg;
      FREQUENCY_ORDER_ERROR_O <= state_reg == csp_pkg::L_BAD && blink_reg;
      RUN_MODE_O <= state_reg == csp_pkg::L_RUN;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= '0;
    end else if (!RD_I) begin
      RDATA_O <= '0;
    end else begin
      case (ADDR_I)
        csp_pkg::A_RATE: RDATA_O <= {30'h0, rate_sel_reg};
        csp_pkg::A_STAT: RDATA_O <= {15'h0, ovf_reg, 2'h0, pend_reg};
        csp_pkg::A_DLO: RDATA_O <= dlo_reg;
        csp_pkg::A_DHI: RDATA_O <= {24'h0, dhi_reg};
        csp_pkg::A_VIEW: RDATA_O <= state_reg == csp_pkg::L_FREQ ?
          freq_mem[pi] : state_reg == csp_pkg::L_DIV ? div_mem[pi][31:0] :
          {27'h0, idx_reg};
        csp_pkg::A_VHI: RDATA_O <= state_reg == csp_pkg::L_DIV ?
          {24'h0, div_mem[pi][39:32]} : 32'h0;
        csp_pkg::A_INFO: RDATA_O <= {1'h0, state_reg, 3'h0, bad_pt_reg,
          3'h0, last_reg, 3'h0, idx_reg, 2'h0, unit_reg};
        default: RDATA_O <= '0;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== testbench/csp_pulse_sink.sv
/*
  model of the external device fed by the scaled pulse output.
  assumes it shares the block's clock and sees a clean level.
*/
`timescale 1ns/10ps
`default_nettype none

module csp_pulse_sink (
  input wire logic clk_i, // bench clock
  input wire logic pulse_i, // scaled pulse in
  input wire logic clr_i, // restart the tallies
  output var int count_o, // rising edges seen
  output var int gap_o // shortest rise to rise
);
  logic last_reg;
  int since_reg;

  // a rise is counted only from a known low, so an x never scores
  always_ff @(posedge clk_i) begin
    last_reg <= pulse_i;
    since_reg <= since_reg + 1;
    if (clr_i) begin
      count_o <= 0;
      gap_o <= 1000000;
      since_reg <= 1000000;
    end else if (pulse_i === 1'b1 && last_reg === 1'b0) begin
      count_o <= count_o + 1;
      since_reg <= 1;
      if (since_reg < gap_o) begin
        gap_o <= since_reg;
      end
    end
  end
endmodule

`default_nettype wire

// ===== testbench/csp_top_tb.sv
/*
  self-checking bench of the scaled pulse output and table setup.
  assumes shortened rate, blink and fault counts set below.
*/
`timescale 1ns/10ps
`default_nettype none

module csp_top_tb;
  logic clk = 1'b0;
  logic rst, wr, rd, inc, sclr, pulse, ovf_w, ord_e, run, seen;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d, vf, vl, vh;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int cnt, gap;

  always #4 clk = ~clk;

  // rate 2 keeps its full period: t_rate only steps through it
  csp_top #(.R0_CYC(8), .R1_CYC(16), .R3_CYC(64),
    .BLINK_CYC(4), .BAD_CYC(16)) csp_top_inst (
    .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CNT_INC_I(inc),
    .PULSE_O(pulse), .BUFFER_OVERFLOW_WARNING_O(ovf_w),
    .FREQUENCY_ORDER_ERROR_O(ord_e), .RUN_MODE_O(run));

  csp_pulse_sink csp_pulse_sink_inst (.clk_i(clk), .pulse_i(pulse),
    .clr_i(sclr), .count_o(cnt), .gap_o(gap));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the whole run needs about 12000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t run hung", $time);
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // an idle edge before each strobe keeps one assignment per step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic key(input logic [1:0] k);
    wr_reg(csp_pkg::A_KEY, {30'h0, k});
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    sclr <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    sclr <= 1'b0;
  endtask

  // visit one point: shows then stores its frequency, then shows then stores its divider
  task automatic pt(input logic [31:0] n, input logic [31:0] f,
    input logic [7:0] dh, input logic [31:0] dl);
    wr_reg(csp_pkg::A_DLO, n);
    key(csp_pkg::KEY_ENTER);
    rd_reg(csp_pkg::A_VIEW, vf);
    wr_reg(csp_pkg::A_DLO, f);
    key(csp_pkg::KEY_ENTER);
    rd_reg(csp_pkg::A_VIEW, vl);
    rd_reg(csp_pkg::A_VHI, vh);
    wr_reg(csp_pkg::A_DHI, {24'h0, dh});
    wr_reg(csp_pkg::A_DLO, dl);
    key(csp_pkg::KEY_ENTER);
  endtask

  task automatic t_reset;
    chk_f(run, 1'b1);
    chk_f(pulse, 1'b0);
    rd_reg(csp_pkg::A_RATE, d);
    chk(d, 32'h0);
    rd_reg(csp_pkg::A_STAT, d);
    chk(d, 32'h0);
    rd_reg(8'hF0, d);
    chk(d, 32'h0);
  endtask

  task automatic t_rate;
    for (int i = 1; i <= 7; i++) begin
      wr_reg(csp_pkg::A_RATE, 32'h1);
      rd_reg(csp_pkg::A_RATE, d);
      chk({30'h0, d[1:0]}, 32'(i % 4));
    end
  endtask

  // increments every other cycle outrun both rates under test
  task automatic t_pulse(input int nin, input int per);
    @(posedge clk);
    sclr <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    repeat (nin) begin
      @(posedge clk);
      inc <= 1'b1;
      @(posedge clk);
      inc <= 1'b0;
    end
    rd_reg(csp_pkg::A_STAT, d);
    chk_f(d[13:0] != 14'h0, 1'b1);
    repeat ((nin + 4) * per) @(posedge clk);
    chk(cnt, nin);
    rd_reg(csp_pkg::A_STAT, d);
    chk(d, 32'h0);
    chk_f(gap >= per, 1'b1);
  endtask

  task automatic t_ovf;
    @(posedge clk);
    inc <= 1'b1;
    repeat (10400) @(posedge clk);
    rd_reg(csp_pkg::A_STAT, d);
    @(posedge clk);
    inc <= 1'b0;
    chk(d & 32'h0001_3FFF, 32'h0001_270F);
    seen = 1'b0;
    repeat (12) @(posedge clk) seen |= (ovf_w === 1'b1);
    chk_f(seen, 1'b1);
    wr_reg(csp_pkg::A_STAT, 32'h0001_0000);
    rd_reg(csp_pkg::A_STAT, d);
    chk_f(d[16], 1'b0);
    seen = 1'b0;
    repeat (12) @(posedge clk) seen |= (ovf_w !== 1'b0);
    chk_f(seen, 1'b0);
    do_reset;
    rd_reg(csp_pkg::A_STAT, d);
    chk(d, 32'h0);
  endtask

  task automatic t_table_ok;
    key(csp_pkg::KEY_OPEN);
    for (int i = 1; i <= 4; i++) begin
      key(csp_pkg::KEY_NEXT);
      rd_reg(csp_pkg::A_INFO, d);
      chk({30'h0, d[1:0]}, 32'(i % 4));
    end
    chk_f(run, 1'b0);
    key(csp_pkg::KEY_NEXT);
    key(csp_pkg::KEY_ENTER);
    pt(32'd1, 32'd0, 8'h00, 32'h0);
    pt(32'd2, 32'd100, 8'hFF, 32'hFFFF_FFFF);
    pt(32'd3, 32'd200, 8'h00, 32'd1000);
    rd_reg(csp_pkg::A_VIEW, d);
    chk(d, 32'd4);
    pt(32'd1, 32'd0, 8'h00, 32'd1000);
    chk(vf, 32'd0);
    chk(vl, {24'h0, csp_pkg::DIV_MIN[7:0]});
    chk(vh, 32'h0);
    pt(32'd2, 32'd100, 8'h00, 32'd1000);
    chk(vf, 32'd100);
    chk(vl, csp_pkg::DIV_MAX[31:0]);
    chk(vh, {24'h0, csp_pkg::DIV_MAX[39:32]});
    rd_reg(csp_pkg::A_VIEW, d);
    chk(d, 32'd3);
    wr_reg(csp_pkg::A_DLO, 32'h0);
    key(csp_pkg::KEY_ENTER);
    for (int i = 0; i < 40 && run !== 1'b1; i++) @(posedge clk);
    chk_f(run, 1'b1);
  endtask

  task automatic t_table_bad;
    key(csp_pkg::KEY_OPEN);
    key(csp_pkg::KEY_ENTER);
    pt(32'd2, 32'd500, 8'h00, 32'd1000);
    wr_reg(csp_pkg::A_DLO, 32'h0);
    key(csp_pkg::KEY_ENTER);
    seen = 1'b0;
    repeat (40) @(posedge clk) seen |= (ord_e === 1'b1);
    chk_f(seen, 1'b1);
    rd_reg(csp_pkg::A_VIEW, d);
    chk(d, 32'd3);
    chk_f(run, 1'b0);
    pt(32'd20, 32'd900, 8'h00, 32'd1000);
    rd_reg(csp_pkg::A_VIEW, d);
    chk(d, 32'd16);
    do_reset;
  endtask

  initial begin
    rst = 1'b1;
    sclr = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    inc = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    sclr <= 1'b0;
    t_reset;
    t_pulse(6, 8);
    t_rate;
    t_pulse(4, 64);
    t_ovf;
    t_table_ok;
    t_table_bad;
    end_sim;
  end
endmodule

`default_nettype wire
